// ---- src/dcr_pkg.sv ----
// Shared constants of the DAC controller register block
package dcr_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_MODE    = 32'h4003c004;
    localparam logic [31:0] ADDR_CH_EN   = 32'h4003c010;
    localparam logic [31:0] ADDR_CH_DIS  = 32'h4003c014;
    localparam logic [31:0] ADDR_CH_STAT = 32'h4003c018;
    localparam logic [31:0] ADDR_CDATA   = 32'h4003c020;
    localparam logic [31:0] ADDR_IRQ_EN  = 32'h4003c024;
    localparam logic [31:0] ADDR_IRQ_DIS = 32'h4003c028;
    localparam logic [31:0] ADDR_IRQ_MSK = 32'h4003c02c;
    localparam logic [31:0] ADDR_IRQ_STS = 32'h4003c030;
    localparam logic [31:0] ADDR_BIAS    = 32'h4003c094;
    localparam logic [31:0] ADDR_PMODE   = 32'h4003c0e4;
    localparam logic [31:0] ADDR_PSTAT   = 32'h4003c0e8;

    // Bus and channel sizes
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned HALF_W   = 16;
    localparam int unsigned NUM_CH   = 2;
    localparam int unsigned NUM_IRQ  = 4;

    // Interrupt bit positions
    localparam int unsigned IRQ_TRANSMIT_READY_FLAG  = 0;
    localparam int unsigned IRQ_EOC    = 1;
    localparam int unsigned IRQ_DMA_END_FLAG  = 2;
    localparam int unsigned IRQ_DMA_BUFFER_EMPTY_FLAG = 3;

    // Sticky flag slots
    localparam int unsigned NUM_STK  = 4;
    localparam int unsigned STK_EOC  = 0;
    localparam int unsigned STK_END  = 1;
    localparam int unsigned STK_BUFE = 2;
    localparam int unsigned STK_VIOL = 3;

    // Mode register layout
    localparam int unsigned      MODE_WORD_BIT = 4;
    localparam logic [31:0]      MODE_MASK     = 32'h3f33ff7f;

    // Bias current register layout
    localparam int unsigned      CUR_W         = 2;
    localparam int unsigned      CUR_CH0_LSB   = 0;
    localparam int unsigned      CUR_CH1_LSB   = 2;
    localparam int unsigned      CORE_LSB      = 8;
    localparam logic [31:0]      BIAS_MASK     = 32'h0000030f;

    // Write protection layout
    localparam int unsigned      PEN_BIT       = 0;
    localparam int unsigned      KEY_LSB       = 8;
    localparam int unsigned      KEY_W         = 24;
    localparam logic [23:0]      PROTECT_KEY   = 24'h444143;
    localparam int unsigned      VIOL_FLAG_BIT = 0;
    localparam int unsigned      VIOL_ADDR_LSB = 8;
    localparam int unsigned      VIOL_ADDR_W   = 8;

    // Reset values
    localparam logic [31:0]      RST_WORD      = 32'h00000000;
    localparam logic [1:0]       RST_CH        = 2'h0;
    localparam logic [3:0]       RST_MASK      = 4'h0;
    localparam logic [7:0]       RST_ADDR      = 8'h00;

endpackage

// ---- src/dcr_sticky.sv ----
// One event flag: set by hardware, cleared by a status read or by a counter write
module dcr_sticky (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    logic flag_q;
    logic flag_d;

    // Set wins over clear so no event is lost at a read
    always_comb begin
        flag_d = set_i | (flag_q & ~clr_i);
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule

// ---- src/dcr_top.sv ----
// What this block does
// - Writing one to a channel-enable bit enables that channel; zero bits change nothing.
// - Writing one to a channel-disable bit disables it; bit 0 channel 0, bit 1 channel 1.
// - Channel status reads one for each enabled channel, zero for disabled.
// - Half-word mode takes data bits 15:0; word mode takes all 32 bits as two samples.
// - Four interrupt sources in bits 0..3, enabled, disabled and mask readable.
// - Transmit-ready flag reads one while a new conversion request can be accepted.
// - End-of-conversion flag sets on a completed conversion, clears on status read.
// - DMA end and buffer-empty flags set when counter hits zero, cleared by counter write.
// - Protect-enable bit updates only when the written key field matches.
// - While protected, writes to mode, channel and bias registers are rejected.
// - A rejected write sets the violation flag and captures its address in bits 15:8.
// - Bias register holds per-channel output current and core bias fields driving analog.
module dcr_top
    import dcr_pkg::*;
#(
    parameter int unsigned CH_COUNT = dcr_pkg::NUM_CH
) (
    input  wire logic                      clk_sys_i,
    input  wire logic                      nrst_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [31:0]               paddr_i,
    input  wire logic [dcr_pkg::DATA_W-1:0] pwdata_i,
    output logic      [dcr_pkg::DATA_W-1:0] prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    output logic                           irq_o,
    output logic      [CH_COUNT-1:0]       chan_en_o,
    output logic      [dcr_pkg::DATA_W-1:0] conv_data_o,
    output logic                           conv_word_o,
    output logic                           conv_valid_o,
    input  wire logic                      conv_ready_i,
    input  wire logic                      conv_done_i,
    input  wire logic                      dma_cnt_zero_i,
    input  wire logic                      dma_cnt_write_i,
    output logic      [dcr_pkg::DATA_W-1:0] mode_o,
    output logic      [dcr_pkg::CUR_W-1:0]  out_current_ch0_o,
    output logic      [dcr_pkg::CUR_W-1:0]  out_current_ch1_o,
    output logic      [dcr_pkg::CUR_W-1:0]  core_bias_o
);
    import dcr_pkg::*;

    // Register layout only has room for two channel bits
    if (CH_COUNT < 1 || CH_COUNT > NUM_CH) begin : g_bad_ch
        $error("dcr_top: CH_COUNT must be 1 or 2");
    end

    // Bus phase decode
    logic setup_ph;
    logic access_ph;
    logic wr_acc;
    logic rd_acc;
    logic addr_hit;

    assign setup_ph  = psel_i & ~penable_i;
    assign access_ph = psel_i & penable_i;
    assign wr_acc    = access_ph & pwrite_i;
    assign rd_acc    = access_ph & ~pwrite_i;

    // Register selects
    logic sel_mode;
    logic sel_chen;
    logic sel_chdis;
    logic sel_chst;
    logic sel_cdata;
    logic sel_ien;
    logic sel_idis;
    logic sel_imsk;
    logic sel_ists;
    logic sel_bias;
    logic sel_pmode;
    logic sel_pstat;

    assign sel_mode  = (paddr_i == ADDR_MODE);
    assign sel_chen  = (paddr_i == ADDR_CH_EN);
    assign sel_chdis = (paddr_i == ADDR_CH_DIS);
    assign sel_chst  = (paddr_i == ADDR_CH_STAT);
    assign sel_cdata = (paddr_i == ADDR_CDATA);
    assign sel_ien   = (paddr_i == ADDR_IRQ_EN);
    assign sel_idis  = (paddr_i == ADDR_IRQ_DIS);
    assign sel_imsk  = (paddr_i == ADDR_IRQ_MSK);
    assign sel_ists  = (paddr_i == ADDR_IRQ_STS);
    assign sel_bias  = (paddr_i == ADDR_BIAS);
    assign sel_pmode = (paddr_i == ADDR_PMODE);
    assign sel_pstat = (paddr_i == ADDR_PSTAT);

    assign addr_hit = sel_mode | sel_chen | sel_chdis | sel_chst | sel_cdata | sel_ien
                    | sel_idis | sel_imsk | sel_ists | sel_bias | sel_pmode | sel_pstat;

    // Zero wait states; unmapped addresses answer with an error
    assign pready_o  = 1'b1;
    assign pslverr_o = access_ph & ~addr_hit;

    // Protection check on every write to a guarded register
    logic prot_q;
    logic guarded_sel;
    logic prot_reject;
    logic wr_ok;

    assign guarded_sel = sel_mode | sel_chen | sel_chdis | sel_bias;
    assign prot_reject = wr_acc & guarded_sel & prot_q;
    assign wr_ok       = wr_acc & ~prot_reject;

    // Protect enable state
    logic prot_d;
    logic key_ok;

    assign key_ok = (pwdata_i[KEY_LSB +: KEY_W] == PROTECT_KEY);

    always_comb begin
        prot_d = prot_q;
        if (wr_acc && sel_pmode && key_ok) begin
            prot_d = pwdata_i[PEN_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prot_q <= 1'b0;
        end else begin
            prot_q <= prot_d;
        end
    end

    // Mode, channel enables and bias currents
    logic [DATA_W-1:0]   mode_q;
    logic [DATA_W-1:0]   mode_d;
    logic [CH_COUNT-1:0] chan_q;
    logic [CH_COUNT-1:0] chan_d;
    logic [DATA_W-1:0]   bias_q;
    logic [DATA_W-1:0]   bias_d;

    // Enable and disable are separate strobes; bits written zero leave channels alone
    always_comb begin
        mode_d = mode_q;
        chan_d = chan_q;
        bias_d = bias_q;
        if (wr_ok && sel_mode) begin
            mode_d = pwdata_i & MODE_MASK;
        end
        if (wr_ok && sel_chen) begin
            chan_d = chan_q | pwdata_i[CH_COUNT-1:0];
        end
        if (wr_ok && sel_chdis) begin
            chan_d = chan_q & ~pwdata_i[CH_COUNT-1:0];
        end
        if (wr_ok && sel_bias) begin
            bias_d = pwdata_i & BIAS_MASK;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_q <= RST_WORD;
            chan_q <= RST_CH[CH_COUNT-1:0];
            bias_q <= RST_WORD;
        end else begin
            mode_q <= mode_d;
            chan_q <= chan_d;
            bias_q <= bias_d;
        end
    end

    // Analog settings go straight out of their registers
    assign mode_o            = mode_q;
    assign chan_en_o         = chan_q;
    assign out_current_ch0_o = bias_q[CUR_CH0_LSB +: CUR_W];
    assign out_current_ch1_o = bias_q[CUR_CH1_LSB +: CUR_W];
    assign core_bias_o       = bias_q[CORE_LSB +: CUR_W];

    // Conversion holding register toward the analog core
    logic              hold_q;
    logic              hold_d;
    logic [DATA_W-1:0] cdata_q;
    logic [DATA_W-1:0] cdata_d;
    logic              cword_q;
    logic              cword_d;
    logic              core_take;
    logic              cdata_load;

    assign core_take  = hold_q & conv_ready_i;
    // A write while the holder is full is dropped unless the core takes the word in that cycle; software waits on transmit ready
    assign cdata_load = wr_acc & sel_cdata & (~hold_q | core_take);

    always_comb begin
        hold_d  = hold_q;
        cdata_d = cdata_q;
        cword_d = cword_q;
        if (core_take) begin
            hold_d = 1'b0;
        end
        if (cdata_load) begin
            hold_d  = 1'b1;
            cword_d = mode_q[MODE_WORD_BIT];
            if (mode_q[MODE_WORD_BIT]) begin
                cdata_d = pwdata_i;
            end else begin
                cdata_d = {{HALF_W{1'b0}}, pwdata_i[HALF_W-1:0]};
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_q  <= 1'b0;
            cdata_q <= RST_WORD;
            cword_q <= 1'b0;
        end else begin
            hold_q  <= hold_d;
            cdata_q <= cdata_d;
            cword_q <= cword_d;
        end
    end

    assign conv_valid_o = hold_q;
    assign conv_data_o  = cdata_q;
    assign conv_word_o  = cword_q;

    // Read data is captured in the setup phase so side effects clear only what was seen
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [NUM_IRQ-1:0] status;
    logic [NUM_IRQ-1:0] mask_q;
    logic [NUM_STK-1:0] stk_flag;
    logic [VIOL_ADDR_W-1:0] vaddr_q;

    // Transmit ready is live, the rest are sticky
    assign status[IRQ_TRANSMIT_READY_FLAG]  = ~hold_q;
    assign status[IRQ_EOC]    = stk_flag[STK_EOC];
    assign status[IRQ_DMA_END_FLAG]  = stk_flag[STK_END];
    assign status[IRQ_DMA_BUFFER_EMPTY_FLAG] = stk_flag[STK_BUFE];

    always_comb begin
        rdata_d = RST_WORD;
        if (setup_ph && !pwrite_i) begin
            if (sel_mode) begin
                rdata_d = mode_q;
            end else if (sel_chst) begin
                rdata_d[CH_COUNT-1:0] = chan_q;
            end else if (sel_imsk) begin
                rdata_d[NUM_IRQ-1:0] = mask_q;
            end else if (sel_ists) begin
                rdata_d[NUM_IRQ-1:0] = status;
            end else if (sel_bias) begin
                rdata_d = bias_q;
            end else if (sel_pmode) begin
                rdata_d[PEN_BIT] = prot_q;
            end else if (sel_pstat) begin
                rdata_d[VIOL_FLAG_BIT] = stk_flag[STK_VIOL];
                rdata_d[VIOL_ADDR_LSB +: VIOL_ADDR_W] = vaddr_q;
            end else begin
                rdata_d = RST_WORD;
            end
        end else begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= RST_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata_o = rdata_q;

    // Interrupt mask: enable sets, disable clears
    logic [NUM_IRQ-1:0] mask_d;

    always_comb begin
        mask_d = mask_q;
        if (wr_acc && sel_ien) begin
            mask_d = mask_q | pwdata_i[NUM_IRQ-1:0];
        end
        if (wr_acc && sel_idis) begin
            mask_d = mask_q & ~pwdata_i[NUM_IRQ-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mask_q <= RST_MASK;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Level interrupt from masked status
    assign irq_o = |(status & mask_q);

    // Sticky flag sources and read clears
    logic [NUM_STK-1:0] stk_set;
    logic [NUM_STK-1:0] stk_clr;
    logic               ists_read;
    logic               pstat_read;

    assign ists_read  = rd_acc & sel_ists;
    assign pstat_read = rd_acc & sel_pstat;

    // Read clears of EOC and violation are gated by the captured read value, so a flag rising mid-read survives
    assign stk_set[STK_EOC]  = conv_done_i;
    assign stk_clr[STK_EOC]  = ists_read & rdata_q[IRQ_EOC];
    assign stk_set[STK_END]  = dma_cnt_zero_i;
    assign stk_clr[STK_END]  = dma_cnt_write_i;
    assign stk_set[STK_BUFE] = dma_cnt_zero_i;
    assign stk_clr[STK_BUFE] = dma_cnt_write_i;
    assign stk_set[STK_VIOL] = prot_reject;
    assign stk_clr[STK_VIOL] = pstat_read & rdata_q[VIOL_FLAG_BIT];

    for (genvar i = 0; i < NUM_STK; i++) begin : g_stk
        dcr_sticky u_stk (
            .clk_sys_i (clk_sys_i),
            .nrst_i    (nrst_i),
            .set_i     (stk_set[i]),
            .clr_i     (stk_clr[i]),
            .flag_o    (stk_flag[i])
        );
    end

    // Violation address capture; a fresh violation beats the read clear
    logic [VIOL_ADDR_W-1:0] vaddr_d;

    always_comb begin
        vaddr_d = vaddr_q;
        if (prot_reject) begin
            vaddr_d = paddr_i[VIOL_ADDR_W-1:0];
        end else if (stk_clr[STK_VIOL]) begin
            vaddr_d = RST_ADDR;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vaddr_q <= RST_ADDR;
        end else begin
            vaddr_q <= vaddr_d;
        end
    end

endmodule

// ---- tb/dcr_core_model.sv ----
// Converter core stand-in: takes one holder word, converts, pulses done
module dcr_core_model (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic stall_i,
    input  wire logic conv_valid_i,
    output logic      conv_ready_o,
    output logic      conv_done_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] busy_q;
    logic [2:0] busy_d;

    // Busy core refuses new samples, so the holder must keep its word
    assign conv_ready_o = !stall_i && (busy_q == 3'h0);

    // Countdown of a conversion in flight
    always_comb begin
        busy_d = busy_q;
        if (conv_valid_i && conv_ready_o) begin
            busy_d = 3'h5;
        end else if (busy_q != 3'h0) begin
            busy_d = busy_q - 3'h1;
        end
    end

    // Done pulse lasts one cycle, at the end of the countdown
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_q      <= 3'h0;
            conv_done_o <= 1'b0;
        end else begin
            busy_q      <= busy_d;
            conv_done_o <= (busy_q == 3'h1);
        end
    end
endmodule

// ---- tb/dcr_top_properties.sv ----
// Port-level checks of the register block
module dcr_top_properties
    import dcr_pkg::*;
#(
    parameter int unsigned CH_COUNT = 2
) (
    input wire logic                 clk_sys_i,
    input wire logic                 nrst_i,
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic                 pwrite_i,
    input wire logic [31:0]          paddr_i,
    input wire logic [DATA_W-1:0]    pwdata_i,
    input wire logic                 pready_o,
    input wire logic [CH_COUNT-1:0]  chan_en_o,
    input wire logic [DATA_W-1:0]    conv_data_o,
    input wire logic                 conv_word_o,
    input wire logic                 conv_valid_o,
    input wire logic                 conv_ready_i,
    input wire logic [DATA_W-1:0]    mode_o,
    input wire logic [CUR_W-1:0]     out_current_ch0_o,
    input wire logic [CUR_W-1:0]     out_current_ch1_o,
    input wire logic [CUR_W-1:0]     core_bias_o
);
    logic wr_acc;
    logic prot_q;
    logic prot_d;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // Shadow of the protect bit, since it is not visible at the ports
    assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
    always_comb begin
        prot_d = prot_q;
        if (wr_acc && paddr_i == ADDR_PMODE && pwdata_i[31:8] == PROTECT_KEY) begin
            prot_d = pwdata_i[0];
        end
    end
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prot_q <= 1'b0;
        end else begin
            prot_q <= prot_d;
        end
    end

    ch_enable_a: assert property (
        wr_acc && paddr_i == ADDR_CH_EN && !prot_q |=>
        chan_en_o == ($past(chan_en_o) | $past(pwdata_i[CH_COUNT-1:0])))
        else $error("channel enable write mismatch");
    ch_disable_a: assert property (
        wr_acc && paddr_i == ADDR_CH_DIS && !prot_q |=>
        chan_en_o == ($past(chan_en_o) & ~$past(pwdata_i[CH_COUNT-1:0])))
        else $error("channel disable write mismatch");
    ch_guard_a: assert property (
        wr_acc && prot_q && (paddr_i == ADDR_CH_EN || paddr_i == ADDR_CH_DIS) |=> $stable(chan_en_o))
        else $error("protected channel write took effect");
    reg_guard_a: assert property (
        wr_acc && prot_q && (paddr_i == ADDR_MODE || paddr_i == ADDR_BIAS) |=>
        $stable(mode_o) && $stable({out_current_ch0_o, out_current_ch1_o, core_bias_o}))
        else $error("protected mode or bias write took effect");
    half_load_a: assert property (
        wr_acc && paddr_i == ADDR_CDATA && !conv_valid_o && !mode_o[MODE_WORD_BIT] |=>
        conv_valid_o && !conv_word_o && conv_data_o == {16'h0000, $past(pwdata_i[15:0])})
        else $error("half word load mismatch");
    word_load_a: assert property (
        wr_acc && paddr_i == ADDR_CDATA && !conv_valid_o && mode_o[MODE_WORD_BIT] |=>
        conv_valid_o && conv_word_o && conv_data_o == $past(pwdata_i))
        else $error("word load mismatch");
    hold_data_a: assert property (
        conv_valid_o && !conv_ready_i |=> conv_valid_o && $stable(conv_data_o))
        else $error("held sample changed before being taken");
    bias_write_a: assert property (
        wr_acc && paddr_i == ADDR_BIAS && !prot_q |=>
        {core_bias_o, out_current_ch1_o, out_current_ch0_o} == {$past(pwdata_i[9:8]), $past(pwdata_i[3:0])})
        else $error("bias fields mismatch");
    mode_write_a: assert property (
        wr_acc && paddr_i == ADDR_MODE && !prot_q |=> mode_o == ($past(pwdata_i) & MODE_MASK))
        else $error("mode write mismatch");
endmodule

bind dcr_top dcr_top_properties #(.CH_COUNT(CH_COUNT)) i_dcr_top_properties (.clk_sys_i, .nrst_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .chan_en_o, .conv_data_o,
    .conv_word_o, .conv_valid_o, .conv_ready_i, .mode_o, .out_current_ch0_o, .out_current_ch1_o,
    .core_bias_o);

// ---- tb/tb_dcr_top.sv ----
// Register-level bench of the DAC controller block
module tb_dcr_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dcr_pkg::*;

    logic        clk, nrst, psel, pen, pwr, irq, pready, err, stall, rerr;
    logic        cword, cvalid, cready, cdone, dzero, dwrite;
    logic [31:0] paddr, pwdata, prdata, cdata, mode, rd;
    logic [1:0]  chan_en, cur0, cur1, core;
    int          n_errors = 0;
    int          compares = 0;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    dcr_top i_dcr_top (.clk_sys_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(err),
        .irq_o(irq), .chan_en_o(chan_en), .conv_data_o(cdata), .conv_word_o(cword),
        .conv_valid_o(cvalid), .conv_ready_i(cready), .conv_done_i(cdone), .dma_cnt_zero_i(dzero),
        .dma_cnt_write_i(dwrite), .mode_o(mode), .out_current_ch0_o(cur0),
        .out_current_ch1_o(cur1), .core_bias_o(core));
    dcr_core_model i_dcr_core_model (.clk_sys_i(clk), .nrst_i(nrst), .stall_i(stall),
        .conv_valid_i(cvalid), .conv_ready_o(cready), .conv_done_o(cdone));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits on pready, never on a fixed count
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            $display("[ERR] %0t no ready from the register slave", $time);
        end
        // Answer taken at the access edge, before the release below lands
        rd   = prdata;
        rerr = err;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    // Bounded wait for the core's done pulse
    task automatic wait_done();
        int n;
        for (n = 0; n < 30 && cdone !== 1'b1; n++) @(posedge clk);
        if (n >= 30) begin
            n_errors++;
            $display("[ERR] %0t no done pulse from the core", $time);
        end
        @(negedge clk);
    endtask

    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        #(5000 * 100);
        n_errors++;
        $display("[ERR] %0t watchdog ran out", $time);
        conclude();
    end

    initial begin
        {nrst, psel, pen, pwr, stall, dzero, dwrite} = 7'h00;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rc(ADDR_CH_STAT, 32'h0);
        rc(ADDR_IRQ_STS, 32'h1);
        rc(ADDR_PSTAT, 32'h0);
        // Channels toggled only while the core is idle
        wr(ADDR_CH_EN, 32'h1);
        rc(ADDR_CH_STAT, 32'h1);
        wr(ADDR_CH_EN, 32'h2);
        rc(ADDR_CH_STAT, 32'h3);
        wr(ADDR_CH_DIS, 32'h1);
        wr(ADDR_CH_DIS, 32'h0);
        rc(ADDR_CH_STAT, 32'h2);
        chk(32'(chan_en), 32'h2);
        // Each interrupt source alone in the mask
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_IRQ_DIS, 32'hf);
            wr(ADDR_IRQ_EN, 32'h1 << i);
            rc(ADDR_IRQ_MSK, 32'h1 << i);
            chk(32'(irq), 32'(i == 0));
        end
        @(negedge clk);
        chk(32'(irq), 32'h0);
        // Half-word sample held by a stalled core
        wr(ADDR_IRQ_DIS, 32'hf);
        wr(ADDR_IRQ_EN, 32'h2);
        stall <= 1'b1;
        wr(ADDR_CDATA, 32'hbeef1234);
        @(negedge clk);
        chk(cdata, 32'h00001234);
        chk(32'(cword), 32'h0);
        rc(ADDR_IRQ_STS, 32'h0);
        stall <= 1'b0;
        wait_done();
        chk(32'(irq), 32'h1);
        rc(ADDR_IRQ_STS, 32'h3);
        rc(ADDR_IRQ_STS, 32'h1);
        // Word mode, second write dropped while the holder is full
        wr(ADDR_MODE, 32'h10);
        stall <= 1'b1;
        wr(ADDR_CDATA, 32'hbeef1234);
        wr(ADDR_CDATA, 32'h5555aaaa);
        @(negedge clk);
        chk(cdata, 32'hbeef1234);
        chk(32'(cword), 32'h1);
        stall <= 1'b0;
        wait_done();
        rc(ADDR_IRQ_STS, 32'h3);
        // Counter events set and clear both transfer flags
        wr(ADDR_IRQ_EN, 32'hc);
        @(posedge clk);
        dzero <= 1'b1;
        @(posedge clk);
        dzero <= 1'b0;
        @(negedge clk);
        chk(32'(irq), 32'h1);
        rc(ADDR_IRQ_STS, 32'hd);
        @(posedge clk);
        dwrite <= 1'b1;
        @(posedge clk);
        dwrite <= 1'b0;
        rc(ADDR_IRQ_STS, 32'h1);
        // Bias fields and their outputs
        wr(ADDR_BIAS, 32'hffffffff);
        rc(ADDR_BIAS, 32'h30f);
        wr(ADDR_BIAS, 32'h206);
        @(negedge clk);
        chk(32'({core, cur1, cur0}), 32'h26);
        // Lock only with the right key, then probe guarded writes
        wr(ADDR_PMODE, 32'h12345601);
        rc(ADDR_PMODE, 32'h0);
        wr(ADDR_PMODE, {PROTECT_KEY, 8'h01});
        rc(ADDR_PMODE, 32'h1);
        wr(ADDR_CH_EN, 32'h1);
        chk(32'(rerr), 32'h0);
        rc(ADDR_CH_STAT, 32'h2);
        rc(ADDR_PSTAT, 32'h1001);
        rc(ADDR_PSTAT, 32'h0);
        wr(ADDR_BIAS, 32'h0);
        rc(ADDR_BIAS, 32'h206);
        rc(ADDR_PSTAT, 32'h9401);
        wr(ADDR_MODE, 32'h0);
        @(negedge clk);
        chk(mode, 32'h10);
        rc(ADDR_MODE, 32'h10);
        wr(ADDR_PMODE, {PROTECT_KEY, 8'h00});
        wr(ADDR_CH_DIS, 32'h3);
        rc(ADDR_CH_STAT, 32'h0);
        // Unlocked mode write keeps only its defined bits; write-only places read zero
        wr(ADDR_MODE, 32'hffffffff);
        rc(ADDR_MODE, MODE_MASK);
        rc(ADDR_CH_EN, 32'h0);
        // Unmapped place answers with an error
        apb(1'b0, 32'h4003c0fc, 32'h0);
        chk(32'(rerr), 32'h1);
        conclude();
    end
endmodule
